// ==== rtl/dcfs_flag_select.sv ====
// Condition flag and result flag logic for the DSP datapath.
// Assumes one operation per cycle from the ALU/shifter, inputs synchronous to clk.
`timescale 1ns/1ps
module dcfs_flag_select (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire dcfs_pkg::dcfs_op_t   op,
  input  wire logic [2:0]           condition_select_field,
  input  wire logic                 saturate_en,
  output dcfs_pkg::dcfs_flags_t     flags,
  output logic                      exec_valid,
  output logic                      exec_grant
);
  import dcfs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    dcfs_flags_t flags;
    logic        exec_valid;
    logic        exec_grant;
  } dcfs_state_t;

  dcfs_state_t state_reg;
  dcfs_state_t state_next;

  logic fix_mixed;
  logic int_mixed;

  ////////////////////////////////////////////////////////////////////////////
  dcfs_sign_span #(
    .WIDTH (FIX_SPAN)
  ) u_fix_span (
    .span_bits  (op.result[GUARD_MSB:WORD_MSB]),
    .span_mixed (fix_mixed)
  );

  dcfs_sign_span #(
    .WIDTH (INT_SPAN)
  ) u_int_span (
    .span_bits  (op.result[GUARD_MSB:INT_LSB]),
    .span_mixed (int_mixed)
  );

  ////////////////////////////////////////////////////////////////////////////
  logic        is_arith;
  logic        is_ashift;
  logic        is_logic;
  logic        is_lshift;
  logic        is_shift;
  logic        arith_like;
  logic        vr;
  logic        neg_full;
  logic        neg_word;
  logic        zero_full;
  logic        zero_word;
  logic        ovf;
  logic        gt;
  logic        dc_carry;
  logic        dc_neg;
  logic        dc_zero;
  logic        dc_ovf;
  logic        dc_greater;
  logic        dc_ge;
  logic        dc;
  logic        grant_cond;
  dcfs_flags_t flags_new;

  // A kind code that is not one-hot claims no class
  always_comb begin
    is_arith  = 1'h0;
    is_ashift = 1'h0;
    is_logic  = 1'h0;
    is_lshift = 1'h0;
    case (op.kind)
      DCFS_ARITH: begin
        is_arith = 1'h1;
      end
      DCFS_LOGIC: begin
        is_logic = 1'h1;
      end
      DCFS_ASHIFT: begin
        is_ashift = 1'h1;
      end
      DCFS_LSHIFT: begin
        is_lshift = 1'h1;
      end
      default: begin
        is_arith = 1'h0;
      end
    endcase
  end

  // Arithmetic shifts share the guard-bit view of arithmetic results
  assign is_shift   = is_ashift | is_lshift;
  assign arith_like = is_arith | is_ashift;

  ////////////////////////////////////////////////////////////////////////////
  // Sign and zero views, with and without the guard bits
  always_comb begin
    neg_full  = op.result[GUARD_MSB];
    neg_word  = op.result[WORD_MSB];
    zero_full = ~|op.result[GUARD_MSB:0];
    // Logical results live in the word below the guard bits only
    zero_word = ~|op.result[WORD_MSB:0];
  end

  // The bit above the guard bits disagrees with the guard MSB only when
  // the result left even the extended range
  always_comb begin
    vr = 1'h0;
    if (op.result[EXT_W-1] != op.result[GUARD_MSB]) begin
      vr = 1'h1;
    end
  end

  // Saturated results clip to range, so range_exceeded is never reported
  always_comb begin
    ovf = 1'h0;
    if (arith_like && !saturate_en) begin
      if (op.int_mode) begin
        ovf = int_mixed;
      end else begin
        ovf = fix_mixed;
      end
    end
  end

  // A zero result is never greater, whatever the sign says
  always_comb begin
    gt = 1'h0;
    if (arith_like) begin
      gt = ~((neg_full ^ vr) | zero_full);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // One candidate flag per select code; the select picks one further down
  always_comb begin
    dc_carry = 1'h0;
    if (is_shift) begin
      dc_carry = op.shift_last_out;
    end else if (is_logic) begin
      dc_carry = 1'h0;
    end else begin
      dc_carry = op.carry_borrow;
    end
  end

  always_comb begin
    dc_neg = 1'h0;
    case (op.kind)
      DCFS_ARITH: begin
        dc_neg = neg_full;
      end
      DCFS_LOGIC: begin
        dc_neg = neg_word;
      end
      DCFS_ASHIFT: begin
        dc_neg = neg_full;
      end
      DCFS_LSHIFT: begin
        dc_neg = neg_word;
      end
      default: begin
        dc_neg = neg_word;
      end
    endcase
  end

  always_comb begin
    dc_zero = 1'h0;
    case (op.kind)
      DCFS_ARITH: begin
        dc_zero = zero_full;
      end
      DCFS_LOGIC: begin
        dc_zero = zero_word;
      end
      DCFS_ASHIFT: begin
        dc_zero = zero_full;
      end
      DCFS_LSHIFT: begin
        dc_zero = zero_word;
      end
      default: begin
        dc_zero = zero_word;
      end
    endcase
  end

  always_comb begin
    dc_ovf = 1'h0;
    case (op.kind)
      DCFS_ARITH: begin
        dc_ovf = ovf;
      end
      DCFS_LOGIC: begin
        dc_ovf = 1'h0;
      end
      DCFS_ASHIFT: begin
        dc_ovf = ovf;
      end
      DCFS_LSHIFT: begin
        dc_ovf = 1'h0;
      end
      default: begin
        dc_ovf = 1'h0;
      end
    endcase
  end

  always_comb begin
    dc_greater = 1'h0;
    case (op.kind)
      DCFS_ARITH: begin
        dc_greater = gt;
      end
      DCFS_LOGIC: begin
        dc_greater = 1'h0;
      end
      DCFS_ASHIFT: begin
        dc_greater = gt;
      end
      DCFS_LSHIFT: begin
        dc_greater = 1'h0;
      end
      default: begin
        dc_greater = 1'h0;
      end
    endcase
  end

  always_comb begin
    dc_ge = 1'h0;
    case (op.kind)
      DCFS_ARITH: begin
        dc_ge = vr ? neg_full : ~neg_full;
      end
      DCFS_LOGIC: begin
        dc_ge = 1'h0;
      end
      DCFS_ASHIFT: begin
        dc_ge = vr ? neg_full : ~neg_full;
      end
      DCFS_LSHIFT: begin
        dc_ge = 1'h0;
      end
      default: begin
        dc_ge = 1'h0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reserved codes: flag held low, software must not use them
  always_comb begin
    dc = 1'h0;
    case (condition_select_field)
      CS_CARRY: begin
        dc = dc_carry;
      end
      CS_NEG: begin
        dc = dc_neg;
      end
      CS_ZERO: begin
        dc = dc_zero;
      end
      CS_OVF: begin
        dc = dc_ovf;
      end
      CS_GREATER: begin
        dc = dc_greater;
      end
      CS_GE: begin
        dc = dc_ge;
      end
      default: begin
        dc = 1'h0;
      end
    endcase
  end

  // Flag word an unconditional operation writes
  always_comb begin
    flags_new                    = '0;
    flags_new.dsp_condition_flag = dc;
    if (arith_like) begin
      flags_new.result_is_less    = neg_full;
      flags_new.all_bits_clear    = zero_full;
      flags_new.range_exceeded    = ovf;
      flags_new.greater_than_flag = gt;
      flags_new.guard_overflow    = vr;
    end else begin
      // Logical kinds read the word without guard bits and never overflow
      flags_new.result_is_less    = neg_word;
      flags_new.all_bits_clear    = zero_word;
      flags_new.range_exceeded    = 1'h0;
      flags_new.greater_than_flag = 1'h0;
      flags_new.guard_overflow    = 1'h0;
    end
  end

  // The test sees the flag left by the last unconditional operation
  always_comb begin
    grant_cond = 1'h0;
    if (state_reg.flags.dsp_condition_flag == op.test_set) begin
      grant_cond = 1'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    // Conditional and idle cycles keep the flags as they are
    state_next            = state_reg;
    state_next.exec_valid = op.valid;
    state_next.exec_grant = 1'h0;
    if (op.valid) begin
      if (op.conditional) begin
        state_next.exec_grant = grant_cond;
      end else begin
        // Unconditional operations ignore the flag they are about to replace
        state_next.exec_grant = 1'h1;
        state_next.flags      = flags_new;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg.flags.dsp_condition_flag <= FLAG_RESET;
      state_reg.flags.result_is_less     <= FLAG_RESET;
      state_reg.flags.all_bits_clear     <= FLAG_RESET;
      state_reg.flags.range_exceeded     <= FLAG_RESET;
      state_reg.flags.greater_than_flag  <= FLAG_RESET;
      state_reg.flags.guard_overflow     <= FLAG_RESET;
      state_reg.exec_valid               <= 1'h0;
      state_reg.exec_grant               <= 1'h0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign flags      = state_reg.flags;
  assign exec_valid = state_reg.exec_valid;
  assign exec_grant = state_reg.exec_grant;

endmodule : dcfs_flag_select

// ==== rtl/dcfs_pkg.sv ====
// Constants and carrier types for the DSP condition flag selector.
// Assumes the ALU and shifter deliver one result per cycle, extended one bit above the guard bits.
package dcfs_pkg;

  localparam int RES_W     = 40;
  localparam int EXT_W     = 41;
  localparam int GUARD_MSB = 39;
  localparam int WORD_MSB  = 31;
  localparam int INT_LSB   = 15;
  localparam int FIX_SPAN  = GUARD_MSB - WORD_MSB + 1;
  localparam int INT_SPAN  = GUARD_MSB - INT_LSB + 1;

  localparam logic [2:0] CS_CARRY   = 3'h0;
  localparam logic [2:0] CS_NEG     = 3'h1;
  localparam logic [2:0] CS_ZERO    = 3'h2;
  localparam logic [2:0] CS_OVF     = 3'h3;
  localparam logic [2:0] CS_GREATER = 3'h4;
  localparam logic [2:0] CS_GE      = 3'h5;

  localparam logic FLAG_RESET = 1'h0;

  typedef enum logic [3:0] {
    DCFS_ARITH     = 4'h1,
    DCFS_LOGIC     = 4'h2,
    DCFS_ASHIFT    = 4'h4,
    DCFS_LSHIFT    = 4'h8
  } dcfs_kind_t;

  typedef struct packed {
    logic             valid;
    logic             conditional;
    logic             test_set;
    dcfs_kind_t       kind;
    logic             int_mode;
    logic             carry_borrow;
    logic             shift_last_out;
    logic [EXT_W-1:0] result;
  } dcfs_op_t;

  typedef struct packed {
    logic dsp_condition_flag;
    logic result_is_less;
    logic all_bits_clear;
    logic range_exceeded;
    logic greater_than_flag;
    logic guard_overflow;
  } dcfs_flags_t;

endpackage : dcfs_pkg

// ==== rtl/dcfs_sign_span.sv ====
// Detects a bit span that is not a pure sign extension.
// Assumes the span is taken from the top of a two's complement value.
`timescale 1ns/1ps
module dcfs_sign_span #(
  parameter int WIDTH = 9
) (
  input  wire logic [WIDTH-1:0] span_bits,
  output logic                  span_mixed
);

  // Mixed ones and zeros mean the value left the narrower range
  assign span_mixed = ~((&span_bits) | (~|span_bits));

endmodule : dcfs_sign_span

// ==== dv/dcfs_flag_monitor.sv ====
// Port checker for the condition flag selector.
// Assumes one clock; bound onto dcfs_flag_select.
`timescale 1ns/1ps
module dcfs_flag_monitor (
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire dcfs_pkg::dcfs_op_t    op,
  input wire logic [2:0]            condition_select_field,
  input wire logic                  saturate_en,
  input wire dcfs_pkg::dcfs_flags_t flags,
  input wire logic                  exec_valid,
  input wire logic                  exec_grant
);
  import dcfs_pkg::*;
  logic [2:0] cs;
  logic       u;
  logic       dc;
  logic       z_exp;
  assign cs = condition_select_field;
  assign z_exp = (op.kind inside {DCFS_ARITH, DCFS_ASHIFT}) ? ~|op.result[GUARD_MSB:0]
                                                            : ~|op.result[WORD_MSB:0];
  assign u  = op.valid && !op.conditional;
  assign dc = flags.dsp_condition_flag;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_cond;
    op.valid && op.conditional;
  endsequence
  ////////////////////////////////////////
  a_cond_hold: assert property (s_cond |=> $stable(flags))
    else $error("flags moved on a conditional op");
  a_cond_grant: assert property (s_cond |=> exec_grant == ($past(dc) == $past(op.test_set)))
    else $error("conditional grant wrong");
  a_uncond_grant: assert property (u |=> exec_valid && exec_grant)
    else $error("unconditional op not granted");
  a_carry_arith: assert property (u && cs == CS_CARRY && op.kind == DCFS_ARITH
    |=> dc == $past(op.carry_borrow))
    else $error("carry flag wrong");
  a_carry_shift: assert property (u && cs == CS_CARRY && op.kind inside {DCFS_ASHIFT, DCFS_LSHIFT}
    |=> dc == $past(op.shift_last_out))
    else $error("shift out flag wrong");
  a_logic_clear: assert property (u && op.kind == DCFS_LOGIC && cs inside {3'h0, 3'h3, 3'h4, 3'h5}
    |=> !dc)
    else $error("logical op left flag set");
  a_neg_arith: assert property (u && cs == CS_NEG && op.kind == DCFS_ARITH
    |=> dc == $past(op.result[GUARD_MSB]))
    else $error("negative flag wrong");
  a_zero_mode: assert property (u && cs == CS_ZERO |=> dc == $past(z_exp))
    else $error("zero flag wrong");
  a_sat_clear: assert property (u && saturate_en |=> !flags.range_exceeded)
    else $error("overflow under saturation");
endmodule : dcfs_flag_monitor
bind dcfs_flag_select dcfs_flag_monitor u_dcfs_flag_monitor (.clk, .rst_n, .op,
  .condition_select_field, .saturate_en, .flags, .exec_valid, .exec_grant);

// ==== dv/dcfs_flag_select_test.sv ====
// Self-checking random bench for the condition flag selector.
// Assumes the monitor is bound in; expectations queue per op.
`timescale 1ns/1ps
module dcfs_flag_select_test;
  import dcfs_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  dcfs_op_t    op = '0;
  logic [2:0]  cs = 3'h0;
  logic        sat = 1'b0;
  dcfs_flags_t flags;
  logic        exec_valid;
  logic        exec_grant;
  logic [6:0]  q[$];
  logic [6:0]  e;
  logic        m_dc = 1'b0;
  logic        m_rx = 1'b0;
  logic [3:0]  m_rf = 4'h0;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          cycles = 0;
  int          seed = 32'h687c190d;
  always #12.5 clk = ~clk;
  dcfs_flag_select u_dcfs_flag_select (.clk, .rst_n, .op, .condition_select_field(cs),
    .saturate_en(sat), .flags, .exec_valid, .exec_grant);
  ////////////////////////////////////////
  task automatic check(input string nm, input logic s, input logic x);
    comparisons++;
    if (s !== x) begin
      n_mismatch++;
      $display("unexpected %s exp %b got %b", nm, x, s);
    end
  endtask : check
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  function automatic logic mix(logic [24:0] s);
    return |s && !(&s);
  endfunction : mix
  task automatic step();
    logic [40:0] r;
    logic ar, n, z, vr, ov, d, g, gtf;
    int t;
    t = $random(seed);
    op.valid = t[0] | t[1];
    op.conditional = t[2] & t[3];
    op.test_set = t[4];
    op.kind = dcfs_kind_t'(4'h1 << t[6:5]);
    op.int_mode = t[7];
    op.carry_borrow = t[8];
    op.shift_last_out = t[9];
    cs = t[12:10] % 3'h6;
    sat = t[13] & t[14];
    // Bias towards zero and small values so every flag value shows up
    r = t[16:15] == 0 ? '0 : t[16:15] == 1 ? 41'($signed(t[24:17])) : {t[31:23], $random(seed)};
    op.result = r;
    ar = op.kind inside {DCFS_ARITH, DCFS_ASHIFT};
    n = ar ? r[39] : r[31];
    z = ar ? r[39:0] == 0 : r[31:0] == 0;
    vr = ar & (r[40] ^ r[39]);
    ov = ar & !sat & mix(op.int_mode ? r[39:15] : {{16{r[39]}}, r[39:31]});
    gtf = ar & !((n ^ vr) | z);
    case (cs)
      CS_CARRY: d = op.kind == DCFS_ARITH ? op.carry_borrow :
                    op.kind == DCFS_LOGIC ? 1'b0 : op.shift_last_out;
      CS_NEG: d = n;
      CS_ZERO: d = z;
      CS_OVF: d = ov;
      CS_GREATER: d = gtf;
      default: d = ar & !(n ^ vr);
    endcase
    g = !op.conditional | (m_dc == op.test_set);
    if (op.valid && !op.conditional) begin
      m_dc = d;
      m_rx = ov;
      m_rf = {n, z, gtf, vr};
    end
    if (op.valid) q.push_back({g, m_dc, m_rx, m_rf});
  endtask : step
  initial begin
    repeat (8) @(posedge clk);
    #2 rst_n = 1'b1;
    check("reset", |flags | exec_valid, 1'b0);
    @(posedge clk);
    repeat (600) begin
      @(posedge clk);
      #2 step();
    end
    @(posedge clk);
    #2 op.valid = 1'b0;
    repeat (3) @(posedge clk);
    check("drained", q.size() == 0, 1'b1);
    stop_test();
  end
  always @(posedge clk) begin
    #1;
    if (exec_valid === 1'b1) begin
      e = q.size() ? q.pop_front() : 'x;
      check("grant", exec_grant, e[6]);
      check("condition", flags.dsp_condition_flag, e[5]);
      check("range", flags.range_exceeded, e[4]);
      check("less", flags.result_is_less, e[3]);
      check("clear", flags.all_bits_clear, e[2]);
      check("greater", flags.greater_than_flag, e[1]);
      check("guard", flags.guard_overflow, e[0]);
    end
  end
  // Ceiling well above the 600 random cycles plus reset
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      stop_test();
    end
  end
endmodule : dcfs_flag_select_test
